/* File: verilog/ocp_pkg.sv */
/*
 * Shared constants and carrier types for one timer compare/PWM channel and its counter.
 * Assumes one kernel clock and a synchronous active-high reset in every user.
 */
// Summary of operation
// - Mode 101 forces reference high; pin follows polarity.
// - Mode 100 forces reference low.
// - Forced modes still compare, flag and request.
// - Match action: 000 hold, 001/010 set/clear, 011 toggle.
// - Every edge-aligned compare match sets the compare flag.
// - Interrupt on match only when enabled.
// - DMA only when enabled; source select picks event.
// - Compare write immediate, or at update with preload.
// - Update event never changes compare-mode outputs.
// - Compare actions resolve to one counter count.
// - Modes 110 and 111 select PWM 1 and 2.
// - Preload moves to shadow only on update.
// - Output enable bit gates pin; polarity selectable.
// - PWM reference changes on compare change or leaving frozen.
// - Alignment 00 edge-aligned; nonzero center-aligned, same waveform.
// - PWM1 up: high while counter below compare.
// - PWM1 down: low while counter above compare.
// - Center flag direction chosen by alignment; 01 down.
// - Center mode: hardware owns direction bit.
// - Center start uses current direction bit.
// - Center counter write: other values keep direction; 0 sets up, reload sets down.
package ocp_pkg;

	localparam int OCP_CNT_W = 16;
	localparam logic [1:0] OCP_CHAN_OUTPUT = 2'h0;
	localparam logic [1:0] OCP_ALIGN_EDGE = 2'h0;
	localparam logic [1:0] OCP_ALIGN_CDOWN = 2'h1;
	localparam logic [1:0] OCP_ALIGN_CUP = 2'h2;
	localparam logic OCP_DIR_UP = 1'h0;
	localparam logic OCP_DIR_DOWN = 1'h1;
	localparam logic OCP_DMA_ON_MATCH = 1'h0;
	localparam logic OCP_RST_LEVEL = 1'h0;

	typedef enum logic [2:0] {
		OCP_MODE_FROZEN = 3'b000,
		OCP_MODE_SET = 3'b001,
		OCP_MODE_CLEAR = 3'b010,
		OCP_MODE_TOGGLE = 3'b011,
		OCP_MODE_FORCE_LOW = 3'b100,
		OCP_MODE_FORCE_HIGH = 3'b101,
		OCP_MODE_PWM1 = 3'b110,
		OCP_MODE_PWM2 = 3'b111
	} ocp_mode_e;

	// Channel configuration bits as software programs them.
	typedef struct packed {
		ocp_mode_e compare_mode_field;
		logic compare_preload_enable;
		logic output_polarity_bit;
		logic output_enable_bit;
		logic [1:0] channel_direction_select;
		logic compare_irq_enable;
		logic compare_dma_enable;
		logic dma_source_select;
	} ocp_chan_cfg_s;

	// Timer control bits as software programs them.
	typedef struct packed {
		logic counter_run_bit;
		logic [1:0] alignment_select;
		logic direction_bit;
		logic reload_preload_enable;
	} ocp_tim_cfg_s;

endpackage : ocp_pkg

/* File: verilog/ocp_counter.sv */
/*
 * Timer counter with reload shadow, edge and center-aligned counting and update events.
 * Assumes control bits come from logic on the same clock; software strobes are one cycle.
 */
`timescale 1ns/100ps
module ocp_counter
	import ocp_pkg::*;
#(
	parameter int CNT_W = OCP_CNT_W
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire ocp_tim_cfg_s i_tim_cfg,
	input wire logic [CNT_W-1:0] i_reload_value,
	input wire logic i_update_generate_bit,
	input wire logic i_counter_write,
	input wire logic [CNT_W-1:0] i_counter_wdata,
	output logic [CNT_W-1:0] o_counter_value,
	output logic o_count_dir,
	output logic o_count_step,
	output logic o_update_event
);

	initial begin
		if (CNT_W < 2 || CNT_W > 32) begin
			$error("ocp_counter: CNT_W must lie in 2..32");
		end
	end

	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] arr_q, arr_d;
	logic dir_q, dir_d;
	logic step_q, step_d;
	logic uev_q, uev_d;
	logic centre;

	assign centre = (i_tim_cfg.alignment_select != OCP_ALIGN_EDGE);

	always_comb begin
		cnt_d = cnt_q;
		dir_d = dir_q;
		step_d = 1'b0;
		uev_d = 1'b0;
		// Outside center mode the direction tracks software, so center mode starts from it.
		if (!centre) begin
			dir_d = i_tim_cfg.direction_bit;
		end
		if (i_update_generate_bit) begin
			cnt_d = dir_q ? arr_q : '0;
			step_d = 1'b1;
			uev_d = 1'b1;
		end else if (i_counter_write) begin
			cnt_d = i_counter_wdata;
			step_d = 1'b1;
			// A write never raises an update; only the two turning values steer direction.
			if (centre) begin
				if (i_counter_wdata == '0) begin
					dir_d = OCP_DIR_UP;
				end else if (i_counter_wdata == arr_q) begin
					dir_d = OCP_DIR_DOWN;
				end
			end
		end else if (i_tim_cfg.counter_run_bit) begin
			step_d = 1'b1;
			if (!centre) begin
				if (dir_q == OCP_DIR_UP) begin
					if (cnt_q == arr_q) begin
						cnt_d = '0;
						uev_d = 1'b1;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end else begin
					if (cnt_q == '0) begin
						cnt_d = arr_q;
						uev_d = 1'b1;
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
			end else if (dir_q == OCP_DIR_UP) begin
				// Above reload the count runs on upward and wraps; direction is kept.
				if (cnt_q == arr_q) begin
					cnt_d = cnt_q - 1'b1;
					dir_d = OCP_DIR_DOWN;
					uev_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end else begin
				if (cnt_q == '0) begin
					cnt_d = cnt_q + 1'b1;
					dir_d = OCP_DIR_UP;
					uev_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		end
		arr_d = arr_q;
		if (!i_tim_cfg.reload_preload_enable || uev_d) begin
			arr_d = i_reload_value;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			cnt_q <= '0;
			arr_q <= '0;
			dir_q <= OCP_DIR_UP;
			step_q <= 1'b0;
			uev_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			arr_q <= arr_d;
			dir_q <= dir_d;
			step_q <= step_d;
			uev_q <= uev_d;
		end
	end

	assign o_counter_value = cnt_q;
	assign o_count_dir = dir_q;
	assign o_count_step = step_q;
	assign o_update_event = uev_q;

endmodule : ocp_counter

/* File: verilog/ocp_channel.sv */
/*
 * One timer channel output stage: compare preload and shadow, compare actions,
 * forced levels, PWM 1/2 in edge and center alignment, flag and requests, plus its counter.
 * Assumes all control inputs come from software-facing logic on i_sys_clk.
 */
`timescale 1ns/100ps
module ocp_channel
	import ocp_pkg::*;
#(
	parameter int CNT_W = OCP_CNT_W
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire ocp_tim_cfg_s i_tim_cfg,
	input wire ocp_chan_cfg_s i_chan_cfg,
	input wire logic [CNT_W-1:0] i_reload_value,
	input wire logic i_update_generate_bit,
	input wire logic i_counter_write,
	input wire logic [CNT_W-1:0] i_counter_wdata,
	input wire logic i_compare_write,
	input wire logic [CNT_W-1:0] i_compare_wdata,
	input wire logic i_flag_clear,
	output logic [CNT_W-1:0] o_counter_value,
	output logic o_count_dir,
	output logic o_update_event,
	output logic [CNT_W-1:0] o_compare_value,
	output logic [CNT_W-1:0] o_compare_shadow,
	output logic o_reference,
	output logic o_channel_output_pin,
	output logic o_channel_output_oe,
	output logic o_compare_match_flag,
	output logic o_irq,
	output logic o_dma_req
);

	initial begin
		if (CNT_W < 2 || CNT_W > 32) begin
			$error("ocp_channel: CNT_W must lie in 2..32");
		end
	end

	// PWM mode 1 level for one counter value; mode 2 is its complement.
	function automatic logic pwm1_level(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp,
		input logic dir);
		if (dir == OCP_DIR_UP) begin
			pwm1_level = (cnt < cmp);
		end else begin
			pwm1_level = !(cnt > cmp);
		end
	endfunction : pwm1_level

	function automatic logic is_pwm(input ocp_mode_e mode);
		is_pwm = (mode == OCP_MODE_PWM1) || (mode == OCP_MODE_PWM2);
	endfunction : is_pwm

	logic [CNT_W-1:0] cnt;
	logic dir;
	logic step;
	logic update_event;

	ocp_counter #(
		.CNT_W(CNT_W)
	) u_counter (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_tim_cfg(i_tim_cfg),
		.i_reload_value(i_reload_value),
		.i_update_generate_bit(i_update_generate_bit),
		.i_counter_write(i_counter_write),
		.i_counter_wdata(i_counter_wdata),
		.o_counter_value(cnt),
		.o_count_dir(dir),
		.o_count_step(step),
		.o_update_event(update_event)
	);

	// Compare preload and shadow registers.
	logic [CNT_W-1:0] pre_q, pre_d;
	logic [CNT_W-1:0] shd_q, shd_d;

	always_comb begin
		pre_d = pre_q;
		if (i_compare_write) begin
			pre_d = i_compare_wdata;
		end
		shd_d = shd_q;
		if (i_chan_cfg.compare_preload_enable) begin
			// The old preload value moves on an update that collides with a write.
			if (update_event) begin
				shd_d = pre_q;
			end
		end else begin
			shd_d = pre_d;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			pre_q <= '0;
			shd_q <= '0;
		end else begin
			pre_q <= pre_d;
			shd_q <= shd_d;
		end
	end

	// Match is qualified by a counter step, so a stopped counter does not re-fire.
	logic out_mode;
	logic match;
	logic flag_dir_ok;
	logic centre;

	assign out_mode = (i_chan_cfg.channel_direction_select == OCP_CHAN_OUTPUT);
	assign centre = (i_tim_cfg.alignment_select != OCP_ALIGN_EDGE);
	assign match = out_mode && step && (cnt == shd_q);

	always_comb begin
		case (i_tim_cfg.alignment_select)
			OCP_ALIGN_EDGE: flag_dir_ok = 1'b1;
			OCP_ALIGN_CDOWN: flag_dir_ok = (dir == OCP_DIR_DOWN);
			OCP_ALIGN_CUP: flag_dir_ok = (dir == OCP_DIR_UP);
			default: flag_dir_ok = 1'b1;
		endcase
	end

	// Reference waveform state.
	logic ref_q, ref_d;
	logic pin_q, pin_d;
	logic pwm_cmp_q, pwm_cmp_d;
	ocp_mode_e mode_q, mode_d;
	ocp_mode_e mode;
	logic pwm_lvl;
	logic pwm_take;

	assign mode = i_chan_cfg.compare_mode_field;

	always_comb begin
		pwm_cmp_d = pwm1_level(cnt, shd_q, dir);
		mode_d = mode;
		pwm_lvl = (mode == OCP_MODE_PWM2) ? !pwm_cmp_d : pwm_cmp_d;
		// Entering from frozen, or swapping mode 1 and 2, reloads the reference at once.
		pwm_take = (pwm_cmp_d != pwm_cmp_q)
			|| (mode_q == OCP_MODE_FROZEN)
			|| (is_pwm(mode_q) && (mode_q != mode));
		ref_d = ref_q;
		if (out_mode) begin
			case (mode)
				OCP_MODE_FROZEN: ref_d = ref_q;
				OCP_MODE_SET: begin
					if (match) begin
						ref_d = 1'b1;
					end
				end
				OCP_MODE_CLEAR: begin
					if (match) begin
						ref_d = 1'b0;
					end
				end
				OCP_MODE_TOGGLE: begin
					if (match) begin
						ref_d = !ref_q;
					end
				end
				OCP_MODE_FORCE_LOW: ref_d = 1'b0;
				OCP_MODE_FORCE_HIGH: ref_d = 1'b1;
				OCP_MODE_PWM1, OCP_MODE_PWM2: begin
					// Center alignment uses the same direction-dependent compare law as edge alignment.
					if (pwm_take) begin
						ref_d = pwm_lvl;
					end
				end
				default: ref_d = ref_q;
			endcase
		end
		// The update event is not a term here, so it never moves the reference.
		pin_d = ref_d ^ i_chan_cfg.output_polarity_bit;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ref_q <= OCP_RST_LEVEL;
			pin_q <= OCP_RST_LEVEL;
			pwm_cmp_q <= 1'b0;
			mode_q <= OCP_MODE_FROZEN;
		end else begin
			ref_q <= ref_d;
			pin_q <= pin_d;
			pwm_cmp_q <= pwm_cmp_d;
			mode_q <= mode_d;
		end
	end

	// Compare flag and requests; forced modes still reach here through match.
	logic flag_q, flag_d;
	logic dma_q, dma_d;
	logic flag_set;

	assign flag_set = match && flag_dir_ok;

	always_comb begin
		flag_d = flag_q;
		if (i_flag_clear) begin
			flag_d = 1'b0;
		end
		// A match in the clearing cycle wins so the event is not lost.
		if (flag_set) begin
			flag_d = 1'b1;
		end
		dma_d = 1'b0;
		if (i_chan_cfg.compare_dma_enable) begin
			if (i_chan_cfg.dma_source_select == OCP_DMA_ON_MATCH) begin
				dma_d = flag_set;
			end else begin
				dma_d = update_event;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			flag_q <= 1'b0;
			dma_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			dma_q <= dma_d;
		end
	end

	assign o_counter_value = cnt;
	assign o_count_dir = dir;
	assign o_update_event = update_event;
	assign o_compare_value = pre_q;
	assign o_compare_shadow = shd_q;
	assign o_reference = ref_q;
	assign o_channel_output_oe = out_mode && i_chan_cfg.output_enable_bit;
	assign o_channel_output_pin = o_channel_output_oe ? pin_q : 1'b0;
	assign o_compare_match_flag = flag_q;
	assign o_irq = flag_q && i_chan_cfg.compare_irq_enable;
	assign o_dma_req = dma_q;

endmodule : ocp_channel

/* File: verification/ocp_channel_properties.sv */
/*
 * Concurrent checks on the compare/PWM channel ports.
 * Assumes the edge-aligned counter for the match checks.
 */
`timescale 1ns/100ps
module ocp_channel_properties
	import ocp_pkg::*;
#(
	parameter int CNT_W = OCP_CNT_W
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire ocp_tim_cfg_s i_tim_cfg,
	input wire ocp_chan_cfg_s i_chan_cfg,
	input wire logic i_compare_write,
	input wire logic [CNT_W-1:0] i_compare_wdata,
	input wire logic [CNT_W-1:0] o_counter_value,
	input wire logic o_count_dir,
	input wire logic o_update_event,
	input wire logic [CNT_W-1:0] o_compare_shadow,
	input wire logic o_reference,
	input wire logic o_channel_output_pin,
	input wire logic o_channel_output_oe,
	input wire logic o_compare_match_flag,
	input wire logic o_irq,
	input wire logic o_dma_req
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	ocp_mode_e md;
	logic sel, edg, r_up, r_dn, pol;
	assign md = i_chan_cfg.compare_mode_field;
	assign sel = i_chan_cfg.channel_direction_select == OCP_CHAN_OUTPUT;
	assign edg = i_tim_cfg.alignment_select == OCP_ALIGN_EDGE;
	assign r_up = o_counter_value < o_compare_shadow;
	assign r_dn = o_counter_value <= o_compare_shadow;
	assign pol = i_chan_cfg.output_polarity_bit;
	// A match only counts on a fresh counter value, so a stalled counter is excluded.
	sequence s_hit;
		$changed(o_counter_value) && o_counter_value == o_compare_shadow && sel && edg;
	endsequence
	sequence s_p1(logic d);
		md == OCP_MODE_PWM1 && o_count_dir == d && edg && sel;
	endsequence
	property p_flag;
		s_hit |=> o_compare_match_flag;
	endproperty
	property p_tog;
		s_hit ##0 md == OCP_MODE_TOGGLE |=> o_reference != $past(o_reference);
	endproperty
	property p_setclr;
		s_hit ##0 (md == OCP_MODE_SET || md == OCP_MODE_CLEAR) |=> o_reference == (
			$past(md) == OCP_MODE_SET);
	endproperty
	property p_fhi;
		sel && md == OCP_MODE_FORCE_HIGH ##1 sel && md == OCP_MODE_FORCE_HIGH |-> o_reference;
	endproperty
	property p_flo;
		sel && md == OCP_MODE_FORCE_LOW ##1 sel && md == OCP_MODE_FORCE_LOW |-> !o_reference;
	endproperty
	property p_pwm_up;
		s_p1(OCP_DIR_UP) ##1 s_p1(OCP_DIR_UP) ##0 ($stable(o_compare_shadow) && r_up != $past(r_up))
			|=> o_reference == $past(r_up);
	endproperty
	property p_pwm_dn;
		s_p1(OCP_DIR_DOWN) ##1 s_p1(OCP_DIR_DOWN) ##0 ($stable(o_compare_shadow) &&
			r_dn != $past(r_dn)) |=> o_reference == $past(r_dn);
	endproperty
	property p_oe;
		o_channel_output_oe == (sel && i_chan_cfg.output_enable_bit);
	endproperty
	property p_pin;
		o_channel_output_oe ##1 o_channel_output_oe && $stable(pol) |->
			o_channel_output_pin == (o_reference ^ pol);
	endproperty
	property p_irq;
		o_irq == (o_compare_match_flag && i_chan_cfg.compare_irq_enable);
	endproperty
	property p_dma;
		o_dma_req |-> $past(i_chan_cfg.compare_dma_enable);
	endproperty
	property p_imm;
		i_compare_write && !i_chan_cfg.compare_preload_enable |=> o_compare_shadow ==
			$past(i_compare_wdata);
	endproperty
	property p_pre;
		$changed(o_compare_shadow) && $past(i_chan_cfg.compare_preload_enable) |->
			o_update_event || $past(o_update_event);
	endproperty
	a_flag: assert property (p_flag) else $error("flag missed");
	a_tog: assert property (p_tog) else $error("no toggle");
	a_setclr: assert property (p_setclr) else $error("bad set or clear");
	a_fhi: assert property (p_fhi) else $error("not forced high");
	a_flo: assert property (p_flo) else $error("not forced low");
	a_pwm_up: assert property (p_pwm_up) else $error("bad pwm up");
	a_pwm_dn: assert property (p_pwm_dn) else $error("bad pwm down");
	a_oe: assert property (p_oe) else $error("bad enable");
	a_pin: assert property (p_pin) else $error("bad pin");
	a_irq: assert property (p_irq) else $error("bad irq");
	a_dma: assert property (p_dma) else $error("bad dma");
	a_imm: assert property (p_imm) else $error("no direct load");
	a_pre: assert property (p_pre) else $error("early load");
	c_hit: cover property (s_hit);
	c_dma: cover property (o_dma_req);
	c_pwm: cover property (md == OCP_MODE_PWM1 && o_reference);
endmodule : ocp_channel_properties

/* File: verification/ocp_load_model.sv */
/*
 * Load on the channel output pin.
 * Assumes a pull-down on the wire, so an undriven pin reads low.
 */
`timescale 1ns/100ps
module ocp_load_model (
	input wire logic i_pin,
	input wire logic i_oe,
	output logic o_level
);
	// The pull-down wins whenever the channel releases the pin.
	assign o_level = i_oe ? i_pin : 1'b0;
endmodule : ocp_load_model

/* File: verification/testbench.sv */
/*
 * Self-checking bench for the compare/PWM channel.
 * Assumes the default 16-bit counter.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module testbench
	import ocp_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_srst, i_update_generate_bit, i_counter_write, i_compare_write, i_flag_clear;
	ocp_tim_cfg_s i_tim_cfg;
	ocp_chan_cfg_s i_chan_cfg;
	logic [15:0] i_reload_value, i_counter_wdata, i_compare_wdata;
	logic [15:0] o_counter_value, o_compare_value, o_compare_shadow;
	logic o_count_dir, o_update_event, o_reference, o_channel_output_pin;
	logic o_channel_output_oe, o_compare_match_flag, o_irq, o_dma_req, load_level;
	int n_fail = 0;
	int compares = 0;
	logic [7:0] hi;
	ocp_mode_e mt[6] = '{OCP_MODE_SET, OCP_MODE_FROZEN, OCP_MODE_CLEAR, OCP_MODE_TOGGLE,
		OCP_MODE_FORCE_HIGH, OCP_MODE_FORCE_LOW};
	logic rt[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	always #25 i_sys_clk = ~i_sys_clk;
	ocp_channel u_ocp_channel (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_tim_cfg(i_tim_cfg),
		.i_chan_cfg(i_chan_cfg),
		.i_reload_value(i_reload_value),
		.i_update_generate_bit(i_update_generate_bit),
		.i_counter_write(i_counter_write),
		.i_counter_wdata(i_counter_wdata),
		.i_compare_write(i_compare_write),
		.i_compare_wdata(i_compare_wdata),
		.i_flag_clear(i_flag_clear),
		.o_counter_value(o_counter_value),
		.o_count_dir(o_count_dir),
		.o_update_event(o_update_event),
		.o_compare_value(o_compare_value),
		.o_compare_shadow(o_compare_shadow),
		.o_reference(o_reference),
		.o_channel_output_pin(o_channel_output_pin),
		.o_channel_output_oe(o_channel_output_oe),
		.o_compare_match_flag(o_compare_match_flag),
		.o_irq(o_irq),
		.o_dma_req(o_dma_req)
	);
	ocp_load_model u_ocp_load_model (
		.i_pin(o_channel_output_pin),
		.i_oe(o_channel_output_oe),
		.o_level(load_level)
	);
	task automatic step(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : step
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask : pulse
	task automatic set_cmp(input logic [15:0] v);
		i_compare_wdata = v;
		pulse(i_compare_write);
	endtask : set_cmp
	// Entering from frozen reloads the reference, so each run starts clean.
	task automatic duty(input ocp_mode_e m, input logic [15:0] c, input logic [7:0] e);
		i_chan_cfg.compare_mode_field = OCP_MODE_FROZEN;
		set_cmp(c);
		pulse(i_update_generate_bit);
		i_chan_cfg.compare_mode_field = m;
		step(12);
		hi = 8'h00;
		for (int k = 0; k < 10; k++) begin
			hi = hi + 8'(o_reference);
			step(1);
		end
		`CHK(hi, e)
	endtask : duty
	task automatic done(input int t);
		$display("test %0d finished", t);
	endtask : done
	task automatic complete_run;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		#(4000 * 50);
		n_fail++;
		complete_run();
	end
	initial begin
		i_srst = 1'b1;
		i_update_generate_bit = 1'b0;
		i_counter_write = 1'b0;
		i_compare_write = 1'b0;
		i_flag_clear = 1'b0;
		i_tim_cfg = '0;
		i_chan_cfg = '0;
		i_reload_value = 16'h0003;
		i_counter_wdata = 16'h0000;
		i_compare_wdata = 16'h0000;
		step(12);
		i_srst = 1'b0;
		`CHK(o_counter_value, 16'h0000)
		`CHK(o_reference, 1'b0)
		done(1);
		i_chan_cfg.compare_mode_field = OCP_MODE_TOGGLE;
		i_chan_cfg.output_enable_bit = 1'b1;
		i_chan_cfg.compare_irq_enable = 1'b1;
		i_chan_cfg.compare_dma_enable = 1'b1;
		set_cmp(16'h0002);
		i_tim_cfg.counter_run_bit = 1'b1;
		for (int k = 0; k < 20 && o_compare_match_flag !== 1'b1; k++) step(1);
		`CHK(o_counter_value, 16'h0003)
		`CHK(o_reference, 1'b1)
		`CHK(load_level, 1'b1)
		`CHK(o_irq, 1'b1)
		foreach (mt[i]) begin
			pulse(i_flag_clear);
			i_chan_cfg.compare_mode_field = mt[i];
			step(4);
			`CHK(o_reference, rt[i])
			`CHK(o_compare_match_flag, 1'b1)
		end
		i_chan_cfg.compare_irq_enable = 1'b0;
		step(1);
		`CHK(o_irq, 1'b0)
		i_chan_cfg.output_polarity_bit = 1'b1;
		step(2);
		`CHK(o_channel_output_pin, 1'b1)
		i_chan_cfg.output_enable_bit = 1'b0;
		step(2);
		`CHK(load_level, 1'b0)
		i_chan_cfg.output_polarity_bit = 1'b0;
		i_chan_cfg.output_enable_bit = 1'b1;
		done(2);
		i_tim_cfg.counter_run_bit = 1'b0;
		i_chan_cfg.compare_mode_field = OCP_MODE_FROZEN;
		i_chan_cfg.compare_preload_enable = 1'b1;
		set_cmp(16'h0001);
		step(6);
		`CHK(o_compare_shadow, 16'h0002)
		pulse(i_update_generate_bit);
		step(2);
		`CHK(o_compare_shadow, 16'h0001)
		done(3);
		i_reload_value = 16'h0009;
		i_tim_cfg.counter_run_bit = 1'b1;
		duty(OCP_MODE_PWM1, 16'h0004, 8'h04);
		duty(OCP_MODE_PWM2, 16'h0004, 8'h06);
		duty(OCP_MODE_PWM1, 16'h0000, 8'h00);
		duty(OCP_MODE_PWM1, 16'h000c, 8'h0a);
		i_tim_cfg.direction_bit = OCP_DIR_DOWN;
		duty(OCP_MODE_PWM1, 16'h0004, 8'h05);
		duty(OCP_MODE_PWM1, 16'h000c, 8'h0a);
		done(4);
		// Direction and alignment are written apart so center counting starts upward.
		i_tim_cfg.counter_run_bit = 1'b0;
		i_tim_cfg.direction_bit = OCP_DIR_UP;
		step(1);
		i_tim_cfg.alignment_select = OCP_ALIGN_CDOWN;
		i_chan_cfg.compare_mode_field = OCP_MODE_FROZEN;
		i_chan_cfg.dma_source_select = 1'b1;
		set_cmp(16'h0004);
		pulse(i_update_generate_bit);
		i_chan_cfg.compare_mode_field = OCP_MODE_PWM1;
		i_tim_cfg.counter_run_bit = 1'b1;
		step(20);
		hi = 8'h00;
		repeat (18) begin
			hi = hi + 8'(o_reference);
			step(1);
		end
		`CHK(hi, 8'h08)
		for (int k = 0; k < 40 && !(o_counter_value == 16'h0004 && o_count_dir == OCP_DIR_UP);
			k++) step(1);
		pulse(i_flag_clear);
		step(2);
		`CHK(o_compare_match_flag, 1'b0)
		for (int k = 0; k < 40 && !(o_counter_value == 16'h0004 && o_count_dir == OCP_DIR_DOWN);
			k++) step(1);
		step(1);
		`CHK(o_compare_match_flag, 1'b1)
		for (int k = 0; k < 40 && o_update_event !== 1'b1; k++) step(1);
		step(1);
		`CHK(o_dma_req, 1'b1)
		i_tim_cfg.counter_run_bit = 1'b0;
		i_counter_wdata = 16'h0000;
		pulse(i_counter_write);
		`CHK(o_count_dir, OCP_DIR_UP)
		`CHK(o_update_event, 1'b0)
		step(1);
		i_counter_wdata = 16'h0009;
		pulse(i_counter_write);
		`CHK(o_count_dir, OCP_DIR_DOWN)
		step(1);
		i_counter_wdata = 16'h00ff;
		pulse(i_counter_write);
		`CHK(o_count_dir, OCP_DIR_DOWN)
		`CHK(o_counter_value, 16'h00ff)
		i_chan_cfg.channel_direction_select = 2'h1;
		step(1);
		`CHK(o_channel_output_oe, 1'b0)
		done(5);
		complete_run();
	end
endmodule : testbench
bind ocp_channel ocp_channel_properties #(.CNT_W(CNT_W)) u_ocp_channel_properties (.*);
